// [pwm_prescaler.sv]
`timescale 1ns/1ps
`include "pwm_timer_params.svh"

// quarter-cycle phase and prescale divider; emits the sub-count bits
// as they will stand after this edge, so a match can clear the pin on
// the very edge that reaches the duty position
module pwm_prescaler
  import pwm_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [1:0] prescale_select,
  output logic increment,
  output logic [1:0] sub_bits
);

  prescale_state_t state;
  prescale_state_t next_state;

  always_comb begin
    next_state = state;
    increment = 1'b0;
    sub_bits = state.phase;
    if (run) begin
      next_state.phase = state.phase + 2'h1;
      if (state.phase == 2'h3) begin
        // ratios of 1, 4 and 16
        unique case (prescale_select)
          2'h0: begin
            increment = 1'b1;
            next_state.pre = 4'h0;
          end
          2'h1: begin
            increment = (state.pre[1:0] == 2'h3);
            next_state.pre = state.pre + 4'h1;
          end
          default: begin
            increment = (state.pre == 4'hf);
            next_state.pre = state.pre + 4'h1;
          end
        endcase
      end
      // with a prescaler the sub-count bits come from the prescaler itself
      unique case (prescale_select)
        2'h0: sub_bits = next_state.phase;
        2'h1: sub_bits = next_state.pre[1:0];
        default: sub_bits = next_state.pre[3:2];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// [pwm_timer.sv]
`timescale 1ns/1ps
`include "pwm_timer_params.svh"

// Contract
// - the period is (period limit + 1) times 4 clocks times the prescale.
// - a count equal to the period limit clears on the next increment.
// - the pin goes high at each restart in pwm mode unless the duty value is zero.
// - each restart in pwm mode copies the duty msb and lsb bits into the shadow and the 2-bit latch.
// - the postscaler only divides period matches, never the pwm period.
// - duty is 10 bits: msb register on top, control bits 5:4 below.
// - high time is the duty value times one clock times the prescale.
// - duty writes land any time, apply after a match; shadow is read-only in pwm mode.
// - shadow plus a 2-bit latch double-buffer the duty value.
// - the pin clears when the buffered duty equals count and sub bits.
// - a duty longer than the period never clears the pin.
// - the prescaler offers ratios of 1, 4 and 16.
// - clearing module control forces the pwm latch low.

module pwm_timer
  import pwm_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_output_pin,
  output logic pwm_output_pin_oe,
  output logic postscale_event
);

  ////////////////////////////////////////////////////////////////////////////
  // state and helpers

  pwm_state_t state;
  pwm_state_t next_state;
  logic increment;
  logic [1:0] sub_bits;
  logic pwm_mode;
  logic timebase_run;

  function automatic logic is_pwm_mode(input logic [7:0] ctrl);
    return (ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] & `MODE_PWM_MASK) == `MODE_PWM;
  endfunction

  function automatic logic [9:0] duty_word(input logic [7:0] msb,
                                           input logic [1:0] lsb);
    return {msb, lsb};
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    return (a == `ADDR_TIMEBASE_COUNT) || (a == `ADDR_PERIOD_LIMIT) ||
           (a == `ADDR_TIMEBASE_CONTROL) || (a == `ADDR_DUTY_MSB) ||
           (a == `ADDR_DUTY_SHADOW) || (a == `ADDR_MODULE_CONTROL) ||
           (a == `ADDR_PORT_DIRECTION);
  endfunction

  assign pwm_mode = is_pwm_mode(state.module_control);
  assign timebase_run = state.timebase_control[`TB_ON_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: 4 clocks per increment times 1, 4 or 16

  pwm_prescaler prescaler_inst (
    .pclk(pclk),
    .presetn(presetn),
    .run(timebase_run),
    .prescale_select(state.timebase_control[`TB_PRE_HI:`TB_PRE_LO]),
    .increment(increment),
    .sub_bits(sub_bits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic setup_ok;
  logic access;
  logic do_write;
  logic period_match;
  logic restart;
  logic [9:0] next_duty;
  logic [9:0] live_duty;
  logic [7:0] wbyte;

  always_comb begin
    next_state = state;
    setup_ok = psel && !penable;
    access = psel && penable;
    do_write = access && pwrite && state.pready;
    wbyte = pwdata[7:0];
    period_match = (state.count == state.period_limit);
    restart = increment && period_match;
    next_duty = duty_word(state.duty_msb,
      state.module_control[`CTRL_DUTY_LSB_HI:`CTRL_DUTY_LSB_LO]);
    live_duty = duty_word(state.duty_shadow, state.duty_lsb_latch);
    next_state.post_event = 1'b0;

    // timebase counter
    if (increment) begin
      if (period_match) begin
        next_state.count = `RST_TIMEBASE_COUNT;
      end else begin
        next_state.count = state.count + 8'h01;
      end
    end

    // postscaler counts matches only; it never touches the period
    if (restart) begin
      if (state.post_count ==
          state.timebase_control[`TB_POST_HI:`TB_POST_LO]) begin
        next_state.post_count = 4'h0;
        next_state.post_event = 1'b1;
      end else begin
        next_state.post_count = state.post_count + 4'h1;
      end
    end

    // pwm waveform
    if (pwm_mode && restart) begin
      next_state.duty_shadow = state.duty_msb;
      next_state.duty_lsb_latch =
        state.module_control[`CTRL_DUTY_LSB_HI:`CTRL_DUTY_LSB_LO];
      next_state.pwm_latch = (next_duty != 10'h000);
    end else if (pwm_mode && timebase_run &&
                 live_duty == {next_state.count, sub_bits}) begin
      // position after this edge: the high time is exactly duty steps
      // duty beyond the period never matches, so the pin stays high
      next_state.pwm_latch = 1'b0;
    end
    if (!pwm_mode) begin
      next_state.pwm_latch = 1'b0;
    end

    // apb: no wait state, yet the read data also comes from a flip-flop set in the setup cycle
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (setup_ok) begin
      next_state.pready = 1'b1;
      next_state.pslverr = !addr_known(paddr);
      unique case (paddr)
        `ADDR_TIMEBASE_COUNT: next_state.prdata = {24'h0, state.count};
        `ADDR_PERIOD_LIMIT: next_state.prdata = {24'h0, state.period_limit};
        `ADDR_TIMEBASE_CONTROL:
          next_state.prdata = {24'h0, 1'b0, state.timebase_control[6:0]};
        `ADDR_DUTY_MSB: next_state.prdata = {24'h0, state.duty_msb};
        `ADDR_DUTY_SHADOW: next_state.prdata = {24'h0, state.duty_shadow};
        `ADDR_MODULE_CONTROL:
          next_state.prdata = {24'h0, 2'h0, state.module_control[5:0]};
        `ADDR_PORT_DIRECTION:
          next_state.prdata = {24'h0, state.port_direction};
        default: next_state.prdata = 32'h0;
      endcase
    end
    if (access && state.pready) begin
      next_state.pready = 1'b0;
    end

    // writes land at any time; an increment blocks a count write, but a module control clear beats the restart pin set
    if (do_write) begin
      unique case (paddr)
        `ADDR_TIMEBASE_COUNT: begin
          if (!increment) begin
            next_state.count = wbyte;
          end
        end
        `ADDR_PERIOD_LIMIT: next_state.period_limit = wbyte;
        `ADDR_TIMEBASE_CONTROL: next_state.timebase_control = {1'b0, wbyte[6:0]};
        `ADDR_DUTY_MSB: next_state.duty_msb = wbyte;
        `ADDR_DUTY_SHADOW: begin
          // read-only while in pwm mode
          if (!pwm_mode) begin
            next_state.duty_shadow = wbyte;
          end
        end
        `ADDR_MODULE_CONTROL: begin
          next_state.module_control = {2'h0, wbyte[5:0]};
          if (wbyte[5:0] == 6'h00) begin
            next_state.pwm_latch = 1'b0;
          end
        end
        `ADDR_PORT_DIRECTION: next_state.port_direction = wbyte;
        default: begin
        end
      endcase
    end

    // pin drives only while its direction bit is cleared
    next_state.pin_oe = !next_state.port_direction[`DIR_PWM_BIT];
    next_state.pin_out = next_state.pwm_latch;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
      state.count <= `RST_TIMEBASE_COUNT;
      state.period_limit <= `RST_PERIOD_LIMIT;
      state.timebase_control <= `RST_TIMEBASE_CONTROL;
      state.duty_msb <= `RST_DUTY;
      state.duty_shadow <= `RST_DUTY;
      state.module_control <= `RST_MODULE_CONTROL;
      state.port_direction <= `RST_PORT_DIRECTION;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign pwm_output_pin = state.pin_out;
  assign pwm_output_pin_oe = state.pin_oe;
  assign postscale_event = state.post_event;

endmodule

// [pwm_timer_chk.sv]
`timescale 1ns/1ps
`include "pwm_timer_params.svh"
module pwm_timer_chk
  import pwm_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_output_pin,
  input wire logic pwm_output_pin_oe,
  input wire logic postscale_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence ctrl_off_s;
    pready && pwrite && paddr == `ADDR_MODULE_CONTROL && pwdata[3:2] != 2'h3;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  setup_answer_a: assert property (setup_s |=> pready)
    else $error("no answer one cycle after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  mapped_ok_a: assert property
    (pready && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on a mapped register");
  unmapped_err_a: assert property (pready && paddr > 12'h018 |-> pslverr)
    else $error("no error on unmapped address");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  latch_clear_a: assert property (ctrl_off_s |-> ##[1:4] !pwm_output_pin)
    else $error("pin not forced low");
  post_pulse_a: assert property (postscale_event |=> !postscale_event)
    else $error("postscale event longer than one cycle");
endmodule
bind pwm_timer pwm_timer_chk chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe(pwm_output_pin_oe),
  .postscale_event(postscale_event));

// [pwm_timer_params.svh]
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH

// register byte addresses on the apb bus
`define ADDR_TIMEBASE_COUNT 12'h000
`define ADDR_PERIOD_LIMIT 12'h004
`define ADDR_TIMEBASE_CONTROL 12'h008
`define ADDR_DUTY_MSB 12'h00c
`define ADDR_DUTY_SHADOW 12'h010
`define ADDR_MODULE_CONTROL 12'h014
`define ADDR_PORT_DIRECTION 12'h018

// reset values
`define RST_TIMEBASE_COUNT 8'h00
`define RST_PERIOD_LIMIT 8'hff
`define RST_TIMEBASE_CONTROL 8'h00
`define RST_MODULE_CONTROL 8'h00
`define RST_DUTY 8'h00
`define RST_PORT_DIRECTION 8'hff

// field positions
`define CTRL_DUTY_LSB_HI 5
`define CTRL_DUTY_LSB_LO 4
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 0
`define TB_POST_HI 6
`define TB_POST_LO 3
`define TB_ON_BIT 2
`define TB_PRE_HI 1
`define TB_PRE_LO 0
`define DIR_PWM_BIT 2

// module mode encoding that selects pwm operation
`define MODE_PWM 4'hc
`define MODE_PWM_MASK 4'hc

// system oscillator periods per timebase increment before the prescaler
`define OSC_PER_INCREMENT 4

`endif

// [pwm_timer_pkg.sv]
package pwm_timer_pkg;

  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] pre;
  } prescale_state_t;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period_limit;
    logic [7:0] timebase_control;
    logic [7:0] duty_msb;
    logic [7:0] duty_shadow;
    logic [1:0] duty_lsb_latch;
    logic [7:0] module_control;
    logic [7:0] port_direction;
    logic [3:0] post_count;
    logic post_event;
    logic pwm_latch;
    logic pin_out;
    logic pin_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pwm_state_t;

endpackage

// [testbench.sv]
`timescale 1ns/1ps
`include "pwm_timer_params.svh"
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench
  import pwm_timer_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, pin, oe, pev, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0] d;
  logic [2:0] l;
  logic [1:0] p, post;
  int failures = 0, cmp_count = 0, cyc = 0, seed = 32'h97a211f3;
  int dv, per, hi, lo, n;
  always #2 pclk = ~pclk;
  pwm_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_output_pin(pin), .pwm_output_pin_oe(oe), .postscale_event(pev));
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // worst case is about 7k cycles per pwm case
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      final_report();
    end
  end
  // request held until pready is seen at an edge; data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      apb(1'h0, 12'(i * 4), 8'h00);
      if (i < 7) `CHK("reset value", (i == 1 || i == 6) ? 8'hff : 8'h00, rd)
      `CHK("slave error", 1'(i == 7), er)
    end
    apb(1'h1, `ADDR_TIMEBASE_COUNT, 8'h5a);
    apb(1'h0, `ADDR_TIMEBASE_COUNT, 8'h00);
    `CHK("count rw", 32'h5a, rd)
    apb(1'h1, `ADDR_TIMEBASE_COUNT, 8'h00);
    apb(1'h1, `ADDR_PORT_DIRECTION, 8'hfb);
    repeat (2) @(posedge pclk);
    `CHK("pin enable", 1'h1, oe)
    for (int k = 0; k < 8; k++) begin
      l = 3'($random(seed));
      p = 2'($random(seed));
      post = 2'($random(seed));
      dv = (p == 2'h0) ? 1 : (p == 2'h1) ? 4 : 16;
      per = (l + 1) * 4 * dv;
      // corners first: zero duty, duty equal to period, one step
      d = (k == 0) ? 10'h0 : (k == 1) ? 10'((l + 1) * 4) : (k == 2) ? 10'h1
        : 10'(($random(seed) & 32'h7fffffff) % ((l + 1) * 4));
      apb(1'h1, `ADDR_PERIOD_LIMIT, 8'(l));
      apb(1'h1, `ADDR_DUTY_MSB, d[9:2]);
      apb(1'h1, `ADDR_TIMEBASE_CONTROL, {1'h0, 2'h0, post, 1'h1, p});
      apb(1'h1, `ADDR_MODULE_CONTROL, {2'h0, d[1:0], 4'hc});
      repeat (2 * per + 8) @(posedge pclk);
      if (d == 10'h0 || d >= 10'((l + 1) * 4)) begin
        n = 0;
        repeat (per) begin
          @(posedge pclk);
          n += (pin === 1'h1);
        end
        `CHK("flat level", (d == 10'h0) ? 0 : per, n)
      end else begin
        while (pin !== 1'h0) @(posedge pclk);
        while (pin !== 1'h1) @(posedge pclk);
        hi = 0;
        lo = 0;
        while (pin === 1'h1) begin hi++; @(posedge pclk); end
        while (pin === 1'h0) begin lo++; @(posedge pclk); end
        `CHK("high time", d * dv, hi)
        `CHK("period", per, hi + lo)
      end
      while (pev !== 1'h1) @(posedge pclk);
      n = 0;
      do begin n++; @(posedge pclk); end while (pev !== 1'h1);
      `CHK("postscale", (post + 1) * per, n)
      // shadow must ignore the write and hold the latched msbs
      apb(1'h1, `ADDR_DUTY_SHADOW, ~d[9:2]);
      apb(1'h0, `ADDR_DUTY_SHADOW, 8'h00);
      `CHK("shadow", {24'h0, d[9:2]}, rd)
      apb(1'h1, `ADDR_MODULE_CONTROL, 8'h00);
      repeat (4) @(posedge pclk);
      `CHK("pin cleared", 1'h0, pin)
      apb(1'h1, `ADDR_TIMEBASE_CONTROL, 8'h00);
      apb(1'h1, `ADDR_TIMEBASE_COUNT, 8'h00);
    end
    final_report();
  end
endmodule
